// >>> rtl/nibble_arith_defs.vh
// constants for the nibble arithmetic datapath
`ifndef NIBBLE_ARITH_DEFS_VH
`define NIBBLE_ARITH_DEFS_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define ACC_W        4
`define BADDR_W      7
`define REG_SEL_W    3
`define DIGIT_W      4
`define PC_W         11
`define Q_W          8
`define SIO_W        4
`define DATA_W       8
`define ADDR_W       4
`define INSTR_W      8
`define STACK_DEPTH  3
`define SYNC_W       3

// ----------------------------------------
// field positions
// ----------------------------------------
`define SUM_CARRY_BIT   4
`define REG_SEL_HI      6
`define REG_SEL_LO      4
`define REG_SEL_SMALL   5
`define DIGIT_HI        3
`define PC_TOP          10
`define BADDR_TOP       6
`define CTRL_L_OE       0
`define CTRL_SIO_COUNT  1
`define SYNC_IN0        0
`define SYNC_IN3        1
`define SYNC_SI         2

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_ADD_CARRY_SKIP   8'h30
`define OP_ADD_RAM          8'h31
`define OP_ADD_TEN          8'h4a
`define OP_ADD_IMM_HI       4'h5
`define OP_COMPL_ADD_SKIP   8'h10
`define OP_CLEAR_ACC        8'h00
`define OP_COMPLEMENT       8'h40
`define OP_NO_OP            8'h44
`define OP_CLEAR_CARRY      8'h32
`define OP_SET_CARRY        8'h22
`define OP_XOR_RAM          8'h02
`define OP_LONG_A           8'h23
`define OP_LONG_B           8'h33
`define OP_LONG_HI          4'h6
`define IMM_ZERO            4'h0
`define DECIMAL_TEN         4'ha

// ----------------------------------------
// register indices
// ----------------------------------------
`define REG_ACC      4'h0
`define REG_CARRY    4'h1
`define REG_RAMADDR  4'h2
`define REG_PC       4'h3
`define REG_STACK0   4'h4
`define REG_STACK1   4'h5
`define REG_STACK2   4'h6
`define REG_LATCH    4'h7
`define REG_CTRL     4'h8
`define REG_SIO      4'h9
`define REG_EDGES    4'ha
`define REG_STATUS   4'hb

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_ACC      4'h0
`define RST_BADDR    7'h00
`define RST_PC       11'h000
`define RST_Q        8'h00
`define RST_SIO      4'h0
`define RST_CTRL     2'h0
`define RST_DATA     8'h00

`endif

// >>> rtl/nibble_arith_datapath.v
// four-bit arithmetic datapath with architectural registers
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "nibble_arith_defs.vh"

module nibble_arith_datapath
#(
   parameter LARGE_VARIANT = 1
)
(
   // clock and reset
   input  wire                  I_CLOCK,
   input  wire                  I_RSTN,
   // instruction stream
   input  wire [`INSTR_W-1:0]   I_INSTR,
   input  wire                  I_INSTR_VALID,
   // ram operand
   input  wire [`ACC_W-1:0]     I_RAM_DATA,
   output reg  [`BADDR_W-1:0]   O_RAM_ADDR,
   // register port
   input  wire [`ADDR_W-1:0]    I_ADDR,
   input  wire [`DATA_W-1:0]    I_WDATA,
   input  wire                  I_WR,
   input  wire                  I_RD,
   output reg  [`DATA_W-1:0]    O_RDATA,
   // pins
   input  wire                  I_IN0,
   input  wire                  I_IN3,
   input  wire                  I_SI,
   output reg  [`Q_W-1:0]       O_L_DATA,
   output reg                   O_L_OE,
   output reg                   O_SO,
   // architectural state
   output reg  [`ACC_W-1:0]     O_ACC,
   output reg                   O_CARRY,
   output reg  [`PC_W-1:0]      O_PC,
   output reg                   O_SKIP
);

   // ----------------------------------------
   // fetch states
   // ----------------------------------------
   localparam ST_EXEC    = 3'b001;
   localparam ST_SKIP    = 3'b010;
   localparam ST_OPERAND = 3'b100;

   reg  [2:0]           state_r;
   reg  [2:0]           state_nxt;
   reg  [`ACC_W-1:0]    acc_r;
   reg  [`ACC_W-1:0]    acc_nxt;
   reg                  carry_r;
   reg                  carry_nxt;
   reg  [`BADDR_W-1:0]  baddr_r;
   reg  [`PC_W-1:0]     pc_r;
   reg  [`PC_W-1:0]     pc_nxt;
   reg  [`PC_W-1:0]     stack_r [0:`STACK_DEPTH-1];
   reg  [`Q_W-1:0]      q_r;
   reg  [`SIO_W-1:0]    sio_r;
   reg  [`SIO_W-1:0]    sio_nxt;
   reg  [1:0]           ctrl_r;
   reg                  edge0_r;
   reg                  edge3_r;
   reg  [`SYNC_W-1:0]   sync1_r;
   reg  [`SYNC_W-1:0]   sync2_r;
   reg  [`SYNC_W-1:0]   sync3_r;
   reg  [`SYNC_W-1:0]   level_r;
   reg  [`SYNC_W-1:0]   level_nxt;
   reg  [`DATA_W-1:0]   rdata_nxt;
   reg                  skip_now;
   reg                  long_now;
   reg                  executed;

   // ----------------------------------------
   // operand fields and sums
   // ----------------------------------------
   wire [`ACC_W-1:0]     imm_field;
   wire [`DIGIT_W-1:0]   digit_field;
   wire [`REG_SEL_W-1:0] reg_field;
   wire [`BADDR_W-1:0]   baddr_mask;
   wire [`PC_W-1:0]      pc_mask;
   wire [`ACC_W-1:0]     ram_nib;
   wire [`ACC_W:0]       sum_carry;
   wire [`ACC_W:0]       sum_compl;
   wire [`ACC_W:0]       sum_ram;
   wire [`ACC_W:0]       sum_imm;
   wire [`ACC_W:0]       sum_ten;
   wire                  is_long;
   wire                  fall0;
   wire                  fall3;
   wire                  fall_si;

   // immediate data in the low nibble of the opcode
   assign imm_field = I_INSTR[`DIGIT_HI:0];
   // register write data split into register and digit fields
   assign digit_field = I_WDATA[`DIGIT_HI:0];
   assign reg_field   = I_WDATA[`REG_SEL_HI:`REG_SEL_LO];

   // small variant drops the top register-select and pc bits
   assign baddr_mask = LARGE_VARIANT ? {`BADDR_W{1'b1}}
                     : {1'b0, {(`BADDR_W-1){1'b1}}};
   assign pc_mask    = LARGE_VARIANT ? {`PC_W{1'b1}}
                     : {1'b0, {(`PC_W-1){1'b1}}};

   // ram nibble at the current address is the memory operand
   assign ram_nib = I_RAM_DATA;

   // five-bit sums, top bit is the carry-out
   assign sum_carry = {1'b0, acc_r} + {1'b0, ram_nib}
                    + {{`ACC_W{1'b0}}, carry_r};
   assign sum_compl = {1'b0, ~acc_r} + {1'b0, ram_nib}
                    + {{`ACC_W{1'b0}}, carry_r};
   assign sum_ram   = {1'b0, acc_r} + {1'b0, ram_nib};
   assign sum_imm   = {1'b0, acc_r} + {1'b0, imm_field};
   assign sum_ten   = {1'b0, acc_r} + {1'b0, `DECIMAL_TEN};

   // two-byte opcodes must be skipped as a unit
   assign is_long = (I_INSTR == `OP_LONG_A)
                 || (I_INSTR == `OP_LONG_B)
                 || (I_INSTR[7:4] == `OP_LONG_HI);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // three flops per pin; level moves once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_W; gi = gi + 1)
      begin : g_sync
         always @*
         begin
            if (sync2_r[gi] == sync3_r[gi])
               level_nxt[gi] = sync2_r[gi];
            else
               level_nxt[gi] = level_r[gi];
         end
      end
   endgenerate

   always @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         sync1_r <= {`SYNC_W{1'b1}};
         sync2_r <= {`SYNC_W{1'b1}};
         sync3_r <= {`SYNC_W{1'b1}};
         level_r <= {`SYNC_W{1'b1}};
      end
      else
      begin
         sync1_r <= {I_SI, I_IN3, I_IN0};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         level_r <= level_nxt;
      end
   end

   // high-to-low transitions of the filtered levels
   assign fall0   = level_r[`SYNC_IN0] & ~level_nxt[`SYNC_IN0];
   assign fall3   = level_r[`SYNC_IN3] & ~level_nxt[`SYNC_IN3];
   assign fall_si = level_r[`SYNC_SI] & ~level_nxt[`SYNC_SI];

   // ----------------------------------------
   // instruction decode and execute
   // ----------------------------------------
   // one byte per valid strobe; results land on the next edge
   always @*
   begin
      acc_nxt   = acc_r;
      carry_nxt = carry_r;
      state_nxt = state_r;
      pc_nxt    = pc_r;
      skip_now  = 1'b0;
      long_now  = 1'b0;
      executed  = 1'b0;
      if (I_INSTR_VALID)
      begin
         pc_nxt = (pc_r + {{(`PC_W-1){1'b0}}, 1'b1}) & pc_mask;
         case (state_r)
            ST_OPERAND:
               state_nxt = ST_EXEC;
            ST_SKIP:
            begin
               // fetched but suppressed, second byte follows along
               if (is_long)
                  state_nxt = ST_OPERAND;
               else
                  state_nxt = ST_EXEC;
            end
            default:
            begin
               executed = 1'b1;
               long_now = is_long;
               if (I_INSTR == `OP_ADD_CARRY_SKIP)
               begin
                  acc_nxt   = sum_carry[`ACC_W-1:0];
                  carry_nxt = sum_carry[`SUM_CARRY_BIT];
                  skip_now  = sum_carry[`SUM_CARRY_BIT];
               end
               else if (I_INSTR == `OP_COMPL_ADD_SKIP)
               begin
                  acc_nxt   = sum_compl[`ACC_W-1:0];
                  carry_nxt = sum_compl[`SUM_CARRY_BIT];
                  skip_now  = sum_compl[`SUM_CARRY_BIT];
               end
               else if (I_INSTR[7:4] == `OP_ADD_IMM_HI
                        && imm_field != `IMM_ZERO)
               begin
                  // carry flag left alone, carry-out only skips
                  acc_nxt  = sum_imm[`ACC_W-1:0];
                  skip_now = sum_imm[`SUM_CARRY_BIT];
               end
               else if (I_INSTR == `OP_XOR_RAM)
                  acc_nxt = acc_r ^ ram_nib;
               else if (I_INSTR == `OP_COMPLEMENT)
                  acc_nxt = ~acc_r;
               else if (I_INSTR == `OP_ADD_RAM)
                  acc_nxt = sum_ram[`ACC_W-1:0];
               else if (I_INSTR == `OP_ADD_TEN)
                  acc_nxt = sum_ten[`ACC_W-1:0];
               else if (I_INSTR == `OP_CLEAR_ACC)
                  acc_nxt = `RST_ACC;
               else if (I_INSTR == `OP_CLEAR_CARRY)
                  carry_nxt = 1'b0;
               else if (I_INSTR == `OP_SET_CARRY)
                  carry_nxt = 1'b1;
               // no-op and every other opcode leave acc and carry as is
               if (skip_now)
                  state_nxt = ST_SKIP;
               else if (long_now)
                  state_nxt = ST_OPERAND;
               else
                  state_nxt = ST_EXEC;
            end
         endcase
      end
      // register port write overrides the datapath this cycle
      if (I_WR && I_ADDR == `REG_ACC)
         acc_nxt = I_WDATA[`ACC_W-1:0];
      if (I_WR && I_ADDR == `REG_CARRY)
         carry_nxt = I_WDATA[0];
      if (I_WR && I_ADDR == `REG_PC)
         pc_nxt = {{(`PC_W-`DATA_W){1'b0}}, I_WDATA} & pc_mask;
   end

   // ----------------------------------------
   // serial shifter and counter
   // ----------------------------------------
   // counts falling serial-input edges, or shifts once per executed instruction
   always @*
   begin
      sio_nxt = sio_r;
      if (ctrl_r[`CTRL_SIO_COUNT])
      begin
         if (fall_si)
            sio_nxt = sio_r + {{(`SIO_W-1){1'b0}}, 1'b1};
      end
      else if (executed)
         sio_nxt = {sio_r[`SIO_W-2:0], level_r[`SYNC_SI]};
      if (I_WR && I_ADDR == `REG_SIO)
         sio_nxt = I_WDATA[`SIO_W-1:0];
   end

   // ----------------------------------------
   // architectural registers
   // ----------------------------------------
   // ram contents live outside and are not touched by reset
   always @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         state_r <= ST_EXEC;
         acc_r   <= `RST_ACC;
         carry_r <= 1'b0;
         baddr_r <= `RST_BADDR;
         pc_r    <= `RST_PC;
         q_r     <= `RST_Q;
         sio_r   <= `RST_SIO;
         ctrl_r  <= `RST_CTRL;
      end
      else
      begin
         state_r <= state_nxt;
         acc_r   <= acc_nxt;
         carry_r <= carry_nxt;
         pc_r    <= pc_nxt;
         sio_r   <= sio_nxt;
         if (I_WR && I_ADDR == `REG_RAMADDR)
            baddr_r <= {reg_field, digit_field} & baddr_mask;
         if (I_WR && I_ADDR == `REG_LATCH)
            q_r <= I_WDATA;
         if (I_WR && I_ADDR == `REG_CTRL)
            ctrl_r <= I_WDATA[1:0];
      end
   end

   // return stack levels, loaded from the register port
   generate
      for (gi = 0; gi < `STACK_DEPTH; gi = gi + 1)
      begin : g_stack
         always @(posedge I_CLOCK or negedge I_RSTN)
         begin
            if (!I_RSTN)
               stack_r[gi] <= `RST_PC;
            else if (I_WR && I_ADDR == `REG_STACK0 + gi)
               stack_r[gi] <= {{(`PC_W-`DATA_W){1'b0}}, I_WDATA}
                              & pc_mask;
         end
      end
   endgenerate

   // ----------------------------------------
   // input edge latches
   // ----------------------------------------
   // reading clears them, but a new edge in that cycle wins
   always @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         edge0_r <= 1'b0;
         edge3_r <= 1'b0;
      end
      else
      begin
         if (fall0)
            edge0_r <= 1'b1;
         else if (I_RD && I_ADDR == `REG_EDGES)
            edge0_r <= 1'b0;
         if (fall3)
            edge3_r <= 1'b1;
         else if (I_RD && I_ADDR == `REG_EDGES)
            edge3_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // register read mux
   // ----------------------------------------
   // unmapped indices read as zero
   always @*
   begin
      rdata_nxt = `RST_DATA;
      if (I_ADDR == `REG_ACC)
         rdata_nxt = {4'h0, acc_r};
      else if (I_ADDR == `REG_CARRY)
         rdata_nxt = {7'h00, carry_r};
      else if (I_ADDR == `REG_RAMADDR)
         rdata_nxt = {1'b0, baddr_r};
      else if (I_ADDR == `REG_PC)
         rdata_nxt = pc_r[7:0];
      else if (I_ADDR == `REG_STACK0)
         rdata_nxt = stack_r[0][7:0];
      else if (I_ADDR == `REG_STACK1)
         rdata_nxt = stack_r[1][7:0];
      else if (I_ADDR == `REG_STACK2)
         rdata_nxt = stack_r[2][7:0];
      else if (I_ADDR == `REG_LATCH)
         rdata_nxt = q_r;
      else if (I_ADDR == `REG_CTRL)
         rdata_nxt = {6'h00, ctrl_r};
      else if (I_ADDR == `REG_SIO)
         rdata_nxt = {4'h0, sio_r};
      else if (I_ADDR == `REG_EDGES)
         rdata_nxt = {6'h00, edge3_r, edge0_r};
      else if (I_ADDR == `REG_STATUS)
         rdata_nxt = {5'h00, state_r};
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   // every port comes straight from a flop, one cycle behind state
   always @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         O_RDATA    <= `RST_DATA;
         O_RAM_ADDR <= `RST_BADDR;
         O_L_DATA   <= `RST_Q;
         O_L_OE     <= 1'b0;
         O_SO       <= 1'b0;
         O_ACC      <= `RST_ACC;
         O_CARRY    <= 1'b0;
         O_PC       <= `RST_PC;
         O_SKIP     <= 1'b0;
      end
      else
      begin
         O_RDATA    <= I_RD ? rdata_nxt : `RST_DATA;
         O_RAM_ADDR <= baddr_r;
         O_L_DATA   <= q_r;
         O_L_OE     <= ctrl_r[`CTRL_L_OE];
         O_SO       <= sio_r[`SIO_W-1];
         O_ACC      <= acc_r;
         O_CARRY    <= carry_r;
         O_PC       <= pc_r;
         O_SKIP     <= (state_r == ST_SKIP);
      end
   end

endmodule
`default_nettype wire

// >>> tb/nibble_arith_props.sv
// assertion checker for the nibble arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
`include "nibble_arith_defs.vh"
module nibble_arith_props
(
   // clock and reset
   input wire                I_CLOCK,
   input wire                I_RSTN,
   // stimulus
   input wire [`INSTR_W-1:0] I_INSTR,
   input wire                I_INSTR_VALID,
   input wire [`ACC_W-1:0]   I_RAM_DATA,
   input wire [`ADDR_W-1:0]  I_ADDR,
   input wire [`DATA_W-1:0]  I_WDATA,
   input wire                I_WR,
   // observed state
   input wire [`BADDR_W-1:0] O_RAM_ADDR,
   input wire [`ACC_W-1:0]   O_ACC,
   input wire                O_CARRY,
   input wire [`PC_W-1:0]    O_PC,
   input wire                O_SKIP
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // operand byte of a long opcode is swallowed, so keep it out of checks
   reg        long_r;
   wire [3:0] imm = I_INSTR[3:0];
   wire [6:0] wb  = I_WDATA[6:0];
   always @(posedge I_CLOCK or negedge I_RSTN)
      if (!I_RSTN)
         long_r <= 1'b0;
      else if (I_INSTR_VALID)
         long_r <= I_INSTR == 8'h23 || I_INSTR == 8'h33
            || I_INSTR[7:4] == 4'h6;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_RSTN);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   // a lone executed byte: idle cycle before, no write, not skipped
   sequence s_lone(ok);
      !I_INSTR_VALID && !I_WR ##1
      I_INSTR_VALID && ok && !O_SKIP && !I_WR && !long_r;
   endsequence
   sequence s_gap_skip;
      !I_INSTR_VALID && !I_WR ##1 I_INSTR_VALID && O_SKIP && !I_WR;
   endsequence
   property p_add_carry_skip;
      s_lone(I_INSTR == 8'h30) |-> ##2 O_SKIP == O_CARRY && {O_CARRY, O_ACC}
         == {1'b0, $past(O_ACC, 2)} + $past(I_RAM_DATA, 2) + $past(O_CARRY, 2);
   endproperty
   a_add_carry_skip: assert property (p_add_carry_skip)
      else $error("asc");
   property p_compl_add;
      s_lone(I_INSTR == 8'h10) |-> ##2 O_SKIP == O_CARRY && {O_CARRY, O_ACC}
         == {1'b0, ~$past(O_ACC, 2)} + $past(I_RAM_DATA, 2)
         + $past(O_CARRY, 2);
   endproperty
   a_compl_add: assert property (p_compl_add)
      else $error("complement_add_carry_skip");
   property p_add_imm;
      s_lone(imm != 4'h0 && I_INSTR[7:4] == 4'h5) |-> ##2
         {O_SKIP, O_ACC} == {1'b0, $past(O_ACC, 2)} + $past(imm, 2)
         && O_CARRY == $past(O_CARRY, 2);
   endproperty
   a_add_imm: assert property (p_add_imm)
      else $error("add_immediate_skip");
   property p_xor;
      s_lone(I_INSTR == 8'h02) |-> ##2 !O_SKIP
         && O_ACC == ($past(O_ACC, 2) ^ $past(I_RAM_DATA, 2));
   endproperty
   a_xor: assert property (p_xor)
      else $error("xor");
   property p_complement;
      s_lone(I_INSTR == 8'h40) |-> ##2 !O_SKIP && O_ACC == ~$past(O_ACC, 2)
         && O_CARRY == $past(O_CARRY, 2);
   endproperty
   a_complement: assert property (p_complement)
      else $error("comp");
   property p_add_ram;
      s_lone(I_INSTR == 8'h31) |-> ##2 !O_SKIP && O_CARRY == $past(O_CARRY, 2)
         && O_ACC == $past(O_ACC, 2) + $past(I_RAM_DATA, 2);
   endproperty
   a_add_ram: assert property (p_add_ram)
      else $error("add");
   property p_add_ten;
      s_lone(I_INSTR == 8'h4a) |-> ##2 !O_SKIP
         && O_ACC == $past(O_ACC, 2) + 4'ha;
   endproperty
   a_add_ten: assert property (p_add_ten)
      else $error("add ten");
   property p_carry_ops;
      s_lone(I_INSTR == 8'h22 || I_INSTR == 8'h32) |-> ##2 !O_SKIP
         && O_CARRY == ($past(I_INSTR, 2) == 8'h22) && $stable(O_ACC);
   endproperty
   a_carry_ops: assert property (p_carry_ops)
      else $error("carry op");
   property p_skipped;
      s_gap_skip |-> ##2 O_ACC == $past(O_ACC, 2)
         && O_CARRY == $past(O_CARRY, 2)
         && O_PC == $past(O_PC, 2) + 11'h001;
   endproperty
   a_skipped: assert property (p_skipped)
      else $error("skip");
   property p_ramaddr;
      I_WR && I_ADDR == 4'h2 |-> ##2 O_RAM_ADDR == $past(wb, 2);
   endproperty
   a_ramaddr: assert property (p_ramaddr)
      else $error("ram addr");
   property p_reset;
      $rose(I_RSTN) |-> O_ACC == 4'h0 && O_PC == 11'h000 && !O_CARRY
         && O_RAM_ADDR == 7'h00 && !O_SKIP;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset");
endmodule
bind nibble_arith_datapath nibble_arith_props props_i (.I_CLOCK(I_CLOCK),
   .I_RSTN(I_RSTN), .I_INSTR(I_INSTR), .I_INSTR_VALID(I_INSTR_VALID),
   .I_RAM_DATA(I_RAM_DATA), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
   .O_RAM_ADDR(O_RAM_ADDR), .O_ACC(O_ACC), .O_CARRY(O_CARRY), .O_PC(O_PC),
   .O_SKIP(O_SKIP));
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the nibble arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   reg         clock, rst_n, instr_vld, wr, rd, in0, in3, si;
   reg  [7:0]  instr, wdata;
   reg  [3:0]  ram_data, addr;
   wire [6:0]  ram_addr;
   wire [7:0]  rdata, l_data;
   wire [3:0]  acc;
   wire [10:0] pc;
   wire        l_oe, so, carry, skip;
   integer     bad_count, tests_run, k, j;
   reg  [7:0]  op, v;
   reg  [3:0]  a, m;
   reg         c;
   reg  [5:0]  rexp;
   reg  [10:0] pc_exp;
   // op list and operand sets {a, c, ram}; boundaries at 15 and 16
   localparam [103:0] OPS = {8'h30, 8'h10, 8'h51, 8'h5f, 8'h50, 8'h02,
      8'h40, 8'h31, 8'h4a, 8'h00, 8'h44, 8'h32, 8'h22};
   localparam [35:0] SETS = {4'hf, 1'b1, 4'h1, 4'h7, 1'b0, 4'h8,
      4'h0, 1'b0, 4'h0, 4'ha, 1'b1, 4'h5};
   nibble_arith_datapath #(.LARGE_VARIANT(1)) nibble_arith_datapath_i (
      .I_CLOCK(clock), .I_RSTN(rst_n), .I_INSTR(instr),
      .I_INSTR_VALID(instr_vld), .I_RAM_DATA(ram_data), .O_RAM_ADDR(ram_addr),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_IN0(in0), .I_IN3(in3), .I_SI(si), .O_L_DATA(l_data), .O_L_OE(l_oe),
      .O_SO(so), .O_ACC(acc), .O_CARRY(carry), .O_PC(pc), .O_SKIP(skip));
   always #5 clock = ~clock;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, bad_count);
         if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input string name, input [10:0] e, input [10:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e)
         begin
            bad_count = bad_count + 1;
            $display("[ERR] %s expected %h seen %h", name, e, g);
         end
      end
   endtask
   task wreg(input [3:0] ad, input [7:0] d);
      begin
         @(posedge clock);
         wr <= 1'b1;
         addr <= ad;
         wdata <= d;
         @(posedge clock);
         wr <= 1'b0;
      end
   endtask
   task rraw(input [3:0] ad, output [7:0] d);
      begin
         @(posedge clock);
         rd <= 1'b1;
         addr <= ad;
         @(posedge clock);
         rd <= 1'b0;
         #1;
         d = rdata;
      end
   endtask
   // executes one byte and follows the program counter
   task ex(input [7:0] o, input [3:0] r);
      begin
         @(posedge clock);
         instr <= o;
         ram_data <= r;
         instr_vld <= 1'b1;
         @(posedge clock);
         instr_vld <= 1'b0;
         @(posedge clock);
         #1;
         pc_exp = pc_exp + 11'h001;
         chk("pc", pc_exp, pc);
      end
   endtask
   // result as {skip, carry, acc}
   function [5:0] ref_op(input [7:0] o, input [3:0] x, input cy,
      input [3:0] r);
      reg [4:0] s, t, u;
      begin
         s = {1'b0, x} + r + cy;
         t = {1'b0, ~x} + r + cy;
         u = {1'b0, x} + o[3:0];
         ref_op = {1'b0, cy, x};
         if (o == 8'h30) ref_op = {s[4], s[4], s[3:0]};
         if (o == 8'h10) ref_op = {t[4], t[4], t[3:0]};
         if (o[7:4] == 4'h5 && o[3:0] != 4'h0)
            ref_op = {u[4], cy, u[3:0]};
         if (o == 8'h02) ref_op[3:0] = x ^ r;
         if (o == 8'h40) ref_op[3:0] = ~x;
         if (o == 8'h31) ref_op[3:0] = x + r;
         if (o == 8'h4a) ref_op[3:0] = x + 4'ha;
         if (o == 8'h00) ref_op[3:0] = 4'h0;
         if (o == 8'h32) ref_op[4] = 1'b0;
         if (o == 8'h22) ref_op[4] = 1'b1;
      end
   endfunction
   function [7:0] rmask(input [3:0] i);
      rmask = i == 4'h1 ? 8'h01 : i == 4'h2 ? 8'h7f : i == 4'h8 ? 8'h03 :
         (i == 4'h0 || i == 4'h9) ? 8'h0f : 8'hff;
   endfunction
   // pin falls, filtered edge latched; a read returns it and clears it
   task edge_test(input [7:0] e);
      begin
         v = 8'h00;
         for (k = 0; k < 12 && v === 8'h00; k = k + 1)
            rraw(4'ha, v);
         chk("edge latch", e, v);
         rraw(4'ha, v);
         chk("latch clear", 8'h00, v);
      end
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   // watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge clock);
      bad_count = bad_count + 1;
      complete_run;
   end
   initial
   begin
      clock = 0; rst_n = 0; instr_vld = 0; wr = 0; rd = 0; instr = 0;
      wdata = 0; ram_data = 0; addr = 0; in0 = 1; in3 = 1; si = 1;
      bad_count = 0; tests_run = 0; pc_exp = 0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      for (j = 0; j < 11; j = j + 1)
      begin
         rraw(j[3:0], v);
         chk("reset value", 8'h00, v);
      end
      for (j = 0; j < 10; j = j + 1)
         wreg(j[3:0], 8'hdb);
      for (j = 0; j < 10; j = j + 1)
      begin
         rraw(j[3:0], v);
         chk("rdback", 8'hdb & rmask(j[3:0]), v);
      end
      chk("port latch", 8'hdb, l_data);
      chk("port drive", 1'b1, l_oe);
      chk("ram addr", 7'h5b, ram_addr);
      chk("shift msb", 1'b1, so);
      wreg(4'hc, 8'hff);
      wreg(4'ha, 8'hff);
      rraw(4'hc, v);
      chk("unmapped", 8'h00, v);
      rraw(4'ha, v);
      chk("read only", 8'h00, v);
      pc_exp = 11'h0db;
      @(posedge clock) in0 <= 1'b0;
      edge_test(8'h01);
      @(posedge clock) in0 <= 1'b1;
      in3 <= 1'b0;
      edge_test(8'h02);
      @(posedge clock) in3 <= 1'b1;
      // count mode: one falling serial edge bumps the counter
      si <= 1'b0;
      repeat (6) @(posedge clock);
      rraw(4'h9, v);
      chk("count", 8'h0c, v);
      // shift mode from here on, shifting in the idle-high serial pin
      wreg(4'h8, 8'h01);
      si <= 1'b1;
      wreg(4'h9, 8'h00);
      for (k = 0; k < 13; k = k + 1)
         for (j = 0; j < 4; j = j + 1)
         begin
            op = OPS[8*k +: 8];
            {a, c, m} = SETS[9*j +: 9];
            rexp = ref_op(op, a, c, m);
            wreg(4'h0, {4'h0, a});
            wreg(4'h1, {7'h0, c});
            ex(op, m);
            chk("acc", rexp[3:0], acc);
            chk("carry", rexp[4], carry);
            chk("skip", rexp[5], skip);
            if (rexp[5] === 1'b1)
            begin
               ex(8'h00, m);
               chk("skipped acc", rexp[3:0], acc);
               chk("skip end", 1'b0, skip);
            end
         end
      rraw(4'h9, v);
      chk("shifted", 8'h0f, v);
      chk("shift out", 1'b1, so);
      rraw(4'hb, v);
      chk("status", 8'h01, v);
      @(posedge clock);
      #1;
      chk("rdata idle", 8'h00, rdata);
      // skipped long opcode drops its operand byte as well
      wreg(4'h0, 8'h0f);
      wreg(4'h1, 8'h01);
      ex(8'h30, 4'h1);
      ex(8'h23, 4'h1);
      ex(8'h02, 4'h3);
      chk("long skip", 4'h1, acc);
      ex(8'h4a, 4'h1);
      chk("after long", 4'hb, acc);
      // second reset in mid-run
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      chk("reset acc", 4'h0, acc);
      chk("reset pc", 11'h000, pc);
      chk("reset addr", 7'h00, ram_addr);
      chk("reset latch", 8'h00, l_data);
      complete_run;
   end
endmodule
`default_nettype wire
